//--- design/port_pin_override_pkg.sv
// constants for the port B pin override block
package port_pin_override_pkg;

    localparam int PIN_COUNT = 8;

    // register indexes on the plain register port
    localparam logic [2:0] REG_INPUT   = 3'h0;
    localparam logic [2:0] REG_DIR     = 3'h1;
    localparam logic [2:0] REG_LATCH   = 3'h2;
    localparam logic [2:0] REG_CONTROL = 3'h3;
    localparam logic [2:0] REG_STATUS  = 3'h4;

    // control register fields
    localparam int CTRL_PULLUP_OFF = 0;
    localparam int CTRL_T2_ASYNC   = 1;
    localparam int CTRL_BYPASS     = 2;

    // status register fields
    localparam int STAT_PIN7_CLOCK = 0;
    localparam int STAT_PIN6_CLOCK = 1;

    // oscillator-capable pins
    localparam int OSC_OUT_PIN = 7;
    localparam int OSC_IN_PIN  = 6;

    // {direction, latch, global pull-up off} that turns a pull-up on
    localparam logic [2:0] PULLUP_PATTERN = 3'h2;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] READ_ZERO  = 8'h00;

endpackage : port_pin_override_pkg

//--- design/port_pin_override_mux.sv
// port B pin override mux with register file and clock-pin detach
//
// Operation
// - pull-up override enable selects pull-up value
// - otherwise pull-up on for pattern 0b010
// - direction override enable selects driver enable value
// - otherwise driver enable follows direction bit
// - value override drives pin when enabled
// - otherwise driven level follows output latch
// - toggle override inverts stored output latch
// - input-enable override selects input path enable
// - otherwise input disabled in deep sleep
// - peripheral tap after clamp, before synchroniser
// - analog line connects straight to pad
// - pin 7 oscillator output for crystal clocks
// - pin 6 clock input unless internal RC
// - timer oscillator only with internal RC, async
// - async timer without bypass detaches pin 7
// - async timer detaches pin 6 as input
// - pin 7 clock use reads zero
// - pin 6 clock use reads zero
// - pins 7, 6 feed pin-change sources
// - global pull-up off disables pull-ups without override
// - deep sleep clamps inputs unless overridden
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps

module port_pin_override_mux
    import port_pin_override_pkg::*;
#(
    parameter int WIDTH = PIN_COUNT
)(
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [2:0]       regAddr,
    input  wire logic [7:0]       regWrData,
    input  wire logic             regWrite,
    input  wire logic             regRead,
    output logic      [7:0]       regRdData,
    input  wire logic [WIDTH-1:0] pullupOvrEn,
    input  wire logic [WIDTH-1:0] pullupOvrVal,
    input  wire logic [WIDTH-1:0] dirOvrEn,
    input  wire logic [WIDTH-1:0] dirOvrVal,
    input  wire logic [WIDTH-1:0] valueOvrEn,
    input  wire logic [WIDTH-1:0] valueOvrVal,
    input  wire logic [WIDTH-1:0] toggleOvrEn,
    input  wire logic [WIDTH-1:0] inenOvrEn,
    input  wire logic [WIDTH-1:0] inenOvrVal,
    input  wire logic             deepSleep,
    input  wire logic             clkSelIntRc,
    input  wire logic             clkSelCrystal,
    input  wire logic             oscAmpOut,
    input  wire logic [WIDTH-1:0] padIn,
    output logic      [WIDTH-1:0] padOut,
    output logic      [WIDTH-1:0] padOe,
    output logic      [WIDTH-1:0] padPullup,
    output logic      [WIDTH-1:0] altFnInputTap,
    output logic      [WIDTH-1:0] analogPadLine,
    output logic                  pinChangeSrc7,
    output logic                  pinChangeSrc6
);

    typedef struct packed {
        logic [WIDTH-1:0] pinDirectionBit;
        logic [WIDTH-1:0] pinOutputLatch;
        logic [WIDTH-1:0] syncFirst;
        logic [WIDTH-1:0] pinInputSync;
        logic             globalPullupOff;
        logic             timer2AsyncSel;
        logic             extClockBypass;
        logic [7:0]       rdData;
    } state_t;

    localparam state_t STATE_RESET = '0;

    state_t state;
    state_t next_state;

    logic             pin7Clock;
    logic             pin6Clock;
    logic [WIDTH-1:0] clockMask;
    logic [WIDTH-1:0] inputEnable;
    logic [WIDTH-1:0] clampedIn;
    logic [WIDTH-1:0] portPullup;
    logic [WIDTH-1:0] portOe;
    logic [WIDTH-1:0] portOut;

    // read view of a port byte with clock pins forced low
    function automatic logic [7:0] masked_byte(
        input logic [WIDTH-1:0] value,
        input logic [WIDTH-1:0] mask
    );
        logic [7:0] result;
        result = READ_ZERO;
        result[WIDTH-1:0] = value & ~mask;
        return result;
    endfunction : masked_byte

    // clock pin selection from fuse levels and the async timer bits
    always_comb
    begin
        pin7Clock = clkSelCrystal
                  | (clkSelIntRc & state.timer2AsyncSel
                     & ~state.extClockBypass);
        pin6Clock = ~clkSelIntRc
                  | (clkSelIntRc & state.timer2AsyncSel);
        clockMask = '0;
        clockMask[OSC_OUT_PIN] = pin7Clock;
        clockMask[OSC_IN_PIN]  = pin6Clock;
    end

    // per-pin two-way choices, no flops in the path
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            inputEnable[i] = inenOvrEn[i] ? inenOvrVal[i]
                                          : ~deepSleep;
            portPullup[i] = pullupOvrEn[i] ? pullupOvrVal[i]
                : ({state.pinDirectionBit[i], state.pinOutputLatch[i],
                    state.globalPullupOff} == PULLUP_PATTERN);
            portOe[i] = dirOvrEn[i] ? dirOvrVal[i]
                                    : state.pinDirectionBit[i];
            portOut[i] = valueOvrEn[i] ? valueOvrVal[i]
                                       : state.pinOutputLatch[i];
        end
        // clamp ahead of the schmitt stage
        clampedIn = padIn & inputEnable;
    end

    // pad drive; combinational by design so overrides cost no cycle
    always_comb
    begin
        padPullup = portPullup & ~clockMask;
        padOe     = portOe & ~clockMask;
        padOut    = portOut & ~clockMask;
        // pin 7 carries the amplifier output while it is a clock pin
        if (pin7Clock)
        begin
            padOe[OSC_OUT_PIN]  = 1'b1;
            padOut[OSC_OUT_PIN] = oscAmpOut;
        end
    end

    // peripheral tap is unsynchronised: receivers synchronise it
    assign altFnInputTap = clampedIn;
    assign analogPadLine = padIn;
    assign pinChangeSrc7 = clampedIn[OSC_OUT_PIN];
    assign pinChangeSrc6 = clampedIn[OSC_IN_PIN];
    assign regRdData     = state.rdData;

    always_comb
    begin
        next_state = state;
        next_state.syncFirst    = clampedIn;
        next_state.pinInputSync = state.syncFirst;
        // a peripheral toggle flips the latch on every cycle it is high
        next_state.pinOutputLatch = state.pinOutputLatch
                                  ^ toggleOvrEn;
        next_state.rdData = READ_ZERO;
        if (regWrite)
        begin
            unique case (regAddr)
                REG_INPUT:
                    // writing ones to the input register toggles the latch
                    next_state.pinOutputLatch = state.pinOutputLatch
                        ^ toggleOvrEn ^ regWrData[WIDTH-1:0];
                REG_DIR:
                    next_state.pinDirectionBit = regWrData[WIDTH-1:0];
                REG_LATCH:
                    next_state.pinOutputLatch = regWrData[WIDTH-1:0]
                                              ^ toggleOvrEn;
                REG_CONTROL:
                begin
                    next_state.globalPullupOff =
                        regWrData[CTRL_PULLUP_OFF];
                    next_state.timer2AsyncSel = regWrData[CTRL_T2_ASYNC];
                    next_state.extClockBypass = regWrData[CTRL_BYPASS];
                end
                default:
                    next_state.rdData = READ_ZERO;
            endcase
        end
        if (regRead)
        begin
            unique case (regAddr)
                REG_INPUT:
                    next_state.rdData = masked_byte(state.pinInputSync,
                                                    clockMask);
                REG_DIR:
                    next_state.rdData = masked_byte(state.pinDirectionBit,
                                                    clockMask);
                REG_LATCH:
                    next_state.rdData = masked_byte(state.pinOutputLatch,
                                                    clockMask);
                REG_CONTROL:
                begin
                    next_state.rdData[CTRL_PULLUP_OFF] =
                        state.globalPullupOff;
                    next_state.rdData[CTRL_T2_ASYNC] = state.timer2AsyncSel;
                    next_state.rdData[CTRL_BYPASS]   = state.extClockBypass;
                end
                REG_STATUS:
                begin
                    next_state.rdData[STAT_PIN7_CLOCK] = pin7Clock;
                    next_state.rdData[STAT_PIN6_CLOCK] = pin6Clock;
                end
                default:
                    next_state.rdData = READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            state <= STATE_RESET;
        else
            state <= next_state;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    property p_pullupOvr;
        pullupOvrEn[0] |-> padPullup[0] == pullupOvrVal[0];
    endproperty
    a_pullupOvr: assert property (p_pullupOvr)
        else $error("pull-up does not follow override value");

    property p_pullupSw;
        !pullupOvrEn[0] && state.globalPullupOff |-> !padPullup[0];
    endproperty
    a_pullupSw: assert property (p_pullupSw)
        else $error("pull-up on while globally disabled");

    property p_dirOvr;
        dirOvrEn[1] |-> padOe[1] == dirOvrVal[1];
    endproperty
    a_dirOvr: assert property (p_dirOvr)
        else $error("driver enable ignores direction override");

    property p_dirSw;
        regWrite && regAddr == REG_DIR ##1 !dirOvrEn[1]
            |-> padOe[1] == $past(regWrData[1]);
    endproperty
    a_dirSw: assert property (p_dirSw)
        else $error("driver enable differs from written direction");

    property p_valOvr;
        valueOvrEn[2] && padOe[2] |-> padOut[2] == valueOvrVal[2];
    endproperty
    a_valOvr: assert property (p_valOvr)
        else $error("pin not driven with override value");

    property p_valSw;
        regWrite && regAddr == REG_LATCH && toggleOvrEn[2] == 1'b0
            ##1 !valueOvrEn[2] |-> padOut[2] == $past(regWrData[2]);
    endproperty
    a_valSw: assert property (p_valSw)
        else $error("driven level differs from written latch");

    property p_toggle;
        toggleOvrEn[3] && !regWrite
            |=> state.pinOutputLatch[3] != $past(state.pinOutputLatch[3]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle override did not invert latch");

    property p_inenOvr;
        inenOvrEn[0] |-> altFnInputTap[0] == (padIn[0] & inenOvrVal[0]);
    endproperty
    a_inenOvr: assert property (p_inenOvr)
        else $error("input enable ignores override");

    property p_sleepClamp;
        !inenOvrEn[0] && deepSleep |-> !altFnInputTap[0];
    endproperty
    a_sleepClamp: assert property (p_sleepClamp)
        else $error("input not clamped in deep sleep");

    property p_syncDelay;
        !inenOvrEn[4] && !deepSleep ##1 !inenOvrEn[4] && !deepSleep
            |=> state.pinInputSync[4] == $past(padIn[4], 2);
    endproperty
    a_syncDelay: assert property (p_syncDelay)
        else $error("input register not two cycles behind pad");

    property p_pin7Detach;
        clkSelIntRc && !clkSelCrystal && state.timer2AsyncSel
            && !state.extClockBypass
            |-> padOe[OSC_OUT_PIN] && padOut[OSC_OUT_PIN] == oscAmpOut;
    endproperty
    a_pin7Detach: assert property (p_pin7Detach)
        else $error("pin 7 not driven by amplifier");

    property p_pin6Detach;
        !clkSelIntRc |-> !padOe[OSC_IN_PIN] && !padPullup[OSC_IN_PIN];
    endproperty
    a_pin6Detach: assert property (p_pin6Detach)
        else $error("pin 6 still general i/o as clock pin");

    property p_readZero7;
        regRead && regAddr == REG_DIR && pin7Clock
            |=> !regRdData[OSC_OUT_PIN];
    endproperty
    a_readZero7: assert property (p_readZero7)
        else $error("pin 7 direction reads nonzero as clock pin");

    property p_readZero6;
        regRead && regAddr == REG_LATCH && pin6Clock
            |=> !regRdData[OSC_IN_PIN];
    endproperty
    a_readZero6: assert property (p_readZero6)
        else $error("pin 6 latch reads nonzero as clock pin");

    property p_pinChange;
        !deepSleep && !inenOvrEn[OSC_OUT_PIN] && !inenOvrEn[OSC_IN_PIN]
            |-> pinChangeSrc7 == padIn[OSC_OUT_PIN]
                && pinChangeSrc6 == padIn[OSC_IN_PIN];
    endproperty
    a_pinChange: assert property (p_pinChange)
        else $error("pin-change sources not fed from pins");

    property p_pullupOn;
        !pullupOvrEn[4] && !state.pinDirectionBit[4]
            && state.pinOutputLatch[4] && !state.globalPullupOff
            |-> padPullup[4];
    endproperty
    a_pullupOn: assert property (p_pullupOn)
        else $error("pull-up off for input with latch high");

    property p_valLatch;
        !valueOvrEn[3] |-> padOut[3] == state.pinOutputLatch[3];
    endproperty
    a_valLatch: assert property (p_valLatch)
        else $error("driven level ignores output latch");

    property p_crystalPin7;
        clkSelCrystal |-> padOe[OSC_OUT_PIN] && !padPullup[OSC_OUT_PIN]
            && padOut[OSC_OUT_PIN] == oscAmpOut;
    endproperty
    a_crystalPin7: assert property (p_crystalPin7)
        else $error("pin 7 not an oscillator pin with a crystal");

    property p_pin6Port;
        clkSelIntRc && !state.timer2AsyncSel && !dirOvrEn[OSC_IN_PIN]
            |-> padOe[OSC_IN_PIN] == state.pinDirectionBit[OSC_IN_PIN];
    endproperty
    a_pin6Port: assert property (p_pin6Port)
        else $error("pin 6 lost to timer oscillator without async");

    property p_pin6Async;
        clkSelIntRc && state.timer2AsyncSel
            |-> !padOe[OSC_IN_PIN] && !padPullup[OSC_IN_PIN];
    endproperty
    a_pin6Async: assert property (p_pin6Async)
        else $error("pin 6 still general i/o with async timer");

    property p_sleepPinChange;
        deepSleep && !inenOvrEn[OSC_OUT_PIN] |-> !pinChangeSrc7;
    endproperty
    a_sleepPinChange: assert property (p_sleepPinChange)
        else $error("pin-change source not clamped in deep sleep");

    c_toggle: cover property (toggleOvrEn[3] ##1 toggleOvrEn[3]);
    c_crystal: cover property (clkSelCrystal && regRead
                               && regAddr == REG_DIR);
    c_timerOsc: cover property (clkSelIntRc && state.timer2AsyncSel);
    c_readBack: cover property (regWrite && regAddr == REG_LATCH
                                ##1 regRead && regAddr == REG_LATCH);
    c_sleepOvr: cover property (deepSleep && inenOvrEn[0]
                                && inenOvrVal[0]);

endmodule : port_pin_override_mux

//--- test/peripheral_override_model.sv
// peripheral model that drives the override signals onto the pins
`timescale 1ns/1ps

module peripheral_override_model (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [1:0] role,
    input  wire logic       dataBit,
    input  wire logic       toggleReq,
    output logic      [7:0] pullupOvrEn,
    output logic      [7:0] pullupOvrVal,
    output logic      [7:0] dirOvrEn,
    output logic      [7:0] dirOvrVal,
    output logic      [7:0] valueOvrEn,
    output logic      [7:0] valueOvrVal,
    output logic      [7:0] toggleOvrEn,
    output logic      [7:0] inenOvrEn,
    output logic      [7:0] inenOvrVal
);
    logic [1:0] roleQ;
    logic       dataQ;
    logic       toggleQ;

    // launched just after the edge, as a real peripheral would
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            roleQ   <= 2'h0;
            dataQ   <= 1'b0;
            toggleQ <= 1'b0;
        end
        else
        begin
            roleQ   <= role;
            dataQ   <= dataBit;
            toggleQ <= toggleReq;
        end
    end

    // role 1 drives the pin, role 2 listens, role 3 keeps input awake
    always_comb
    begin
        pullupOvrEn  = 8'h00;
        pullupOvrVal = 8'h00;
        dirOvrEn     = 8'h00;
        dirOvrVal    = 8'h00;
        valueOvrEn   = 8'h00;
        valueOvrVal  = 8'h00;
        inenOvrEn    = 8'h00;
        inenOvrVal   = 8'h00;
        toggleOvrEn  = {8{toggleQ}};
        case (roleQ)
            2'h1:
            begin
                pullupOvrEn = 8'hff;
                dirOvrEn    = 8'hff;
                dirOvrVal   = 8'hff;
                valueOvrEn  = 8'hff;
                valueOvrVal = {8{dataQ}};
            end
            2'h2:
            begin
                pullupOvrEn  = 8'hff;
                pullupOvrVal = {8{dataQ}};
                dirOvrEn     = 8'hff;
                inenOvrEn    = 8'hff;
                inenOvrVal   = {8{dataQ}};
            end
            2'h3:
            begin
                inenOvrEn  = 8'hff;
                inenOvrVal = 8'hff;
            end
            default:
            begin
            end
        endcase
    end
endmodule : peripheral_override_model

//--- test/tb_port_pin_override_mux.sv
// testbench for the port pin override mux
`timescale 1ns/1ps

module tb_port_pin_override_mux
    import port_pin_override_pkg::*;
;
    typedef struct packed {
        logic [1:0] role;
        logic       data;
        logic       pullOff;
        logic       sleep;
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] pu;
        logic [7:0] tap;
    } row_t;

    logic clk_sys, reset_n, regWrite, regRead, deepSleep, dataBit, toggleReq;
    logic clkSelIntRc, clkSelCrystal, oscAmpOut, pinChangeSrc7, pinChangeSrc6;
    logic [1:0] role;
    logic [2:0] regAddr;
    logic [7:0] regWrData, regRdData, padIn, padOut, padOe, padPullup, v;
    logic [7:0] altFnInputTap, analogPadLine, puEn, puVal, dEn, dVal;
    logic [7:0] vEn, vVal, tEn, iEn, iVal;
    int numErrors, checked, cycles;
    // dir 0f, latch 33, padIn a5 in every row
    row_t rows [7] = '{
        '{2'h0, 1'b0, 1'b0, 1'b0, 8'h0f, 8'h03, 8'h30, 8'ha5},
        '{2'h0, 1'b0, 1'b1, 1'b1, 8'h0f, 8'h03, 8'h00, 8'h00},
        '{2'h1, 1'b1, 1'b0, 1'b0, 8'hff, 8'hff, 8'h00, 8'ha5},
        '{2'h1, 1'b0, 1'b0, 1'b0, 8'hff, 8'h00, 8'h00, 8'ha5},
        '{2'h2, 1'b1, 1'b1, 1'b1, 8'h00, 8'h00, 8'hff, 8'ha5},
        '{2'h2, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 8'h00, 8'h00},
        '{2'h3, 1'b0, 1'b0, 1'b1, 8'h0f, 8'h03, 8'h30, 8'ha5}};

    port_pin_override_mux u_port_pin_override_mux (.clk_sys(clk_sys),
        .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .pullupOvrEn(puEn), .pullupOvrVal(puVal), .dirOvrEn(dEn),
        .dirOvrVal(dVal), .valueOvrEn(vEn), .valueOvrVal(vVal),
        .toggleOvrEn(tEn), .inenOvrEn(iEn), .inenOvrVal(iVal),
        .deepSleep(deepSleep), .clkSelIntRc(clkSelIntRc),
        .clkSelCrystal(clkSelCrystal), .oscAmpOut(oscAmpOut), .padIn(padIn),
        .padOut(padOut), .padOe(padOe), .padPullup(padPullup),
        .altFnInputTap(altFnInputTap), .analogPadLine(analogPadLine),
        .pinChangeSrc7(pinChangeSrc7), .pinChangeSrc6(pinChangeSrc6));

    peripheral_override_model u_peripheral_override_model (.clk_sys(clk_sys),
        .reset_n(reset_n), .role(role), .dataBit(dataBit),
        .toggleReq(toggleReq), .pullupOvrEn(puEn), .pullupOvrVal(puVal),
        .dirOvrEn(dEn), .dirOvrVal(dVal), .valueOvrEn(vEn),
        .valueOvrVal(vVal), .toggleOvrEn(tEn), .inenOvrEn(iEn),
        .inenOvrVal(iVal));

    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic writeReg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : writeReg

    // data stand only in the cycle after the read strobe
    task automatic readReg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1 d = regRdData;
    endtask : readReg

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, numErrors);
        if (numErrors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            numErrors++;
            stop_test();
        end
    end

    initial
    begin
        {regWrite, regRead, deepSleep, dataBit, toggleReq} = 5'h00;
        {clkSelCrystal, oscAmpOut, role, regAddr} = 7'h00;
        {regWrData, numErrors, checked, cycles} = '0;
        clkSelIntRc = 1'b1;
        padIn = 8'ha5;
        reset_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        #1 check("padOe", padOe, 8'h00);
        readReg(REG_DIR, v);
        check("dir", v, RESET_BYTE);
        readReg(REG_STATUS, v);
        check("status", v, 8'h00);
        $display("reset test done");
        foreach (rows[i])
        begin
            writeReg(REG_DIR, 8'h0f);
            writeReg(REG_LATCH, 8'h33);
            writeReg(REG_CONTROL, {7'h00, rows[i].pullOff});
            @(posedge clk_sys);
            role      <= rows[i].role;
            dataBit   <= rows[i].data;
            deepSleep <= rows[i].sleep;
            repeat (2) @(posedge clk_sys);
            #1 check("padOe", padOe, rows[i].oe);
            check("padOut", padOut & padOe, rows[i].out);
            check("padPullup", padPullup, rows[i].pu);
            check("tap", altFnInputTap, rows[i].tap);
            check("analog", analogPadLine, padIn);
            check("pinChange", {6'h00, pinChangeSrc7, pinChangeSrc6},
                  {6'h00, rows[i].tap[7:6]});
            $display("row %0d done", i);
        end
        // one-cycle toggle request, then a software toggle
        @(posedge clk_sys);
        role      <= 2'h0;
        deepSleep <= 1'b0;
        toggleReq <= 1'b1;
        @(posedge clk_sys);
        toggleReq <= 1'b0;
        repeat (2) @(posedge clk_sys);
        readReg(REG_LATCH, v);
        check("latch", v, 8'hcc);
        writeReg(REG_INPUT, 8'h0f);
        readReg(REG_LATCH, v);
        check("latch", v, 8'hc3);
        readReg(REG_INPUT, v);
        check("input", v, 8'ha5);
        // pad change must take two edges to reach the input register
        @(posedge clk_sys);
        padIn <= 8'h5a;
        readReg(REG_INPUT, v);
        check("input", v, 8'ha5);
        readReg(REG_INPUT, v);
        check("input", v, 8'h5a);
        writeReg(3'h5, 8'hff);
        readReg(3'h5, v);
        check("unmapped", v, READ_ZERO);
        $display("toggle and map test done");
        writeReg(REG_DIR, 8'hff);
        @(posedge clk_sys);
        clkSelCrystal <= 1'b1;
        clkSelIntRc   <= 1'b0;
        oscAmpOut     <= 1'b1;
        readReg(REG_STATUS, v);
        check("status", v, 8'h03);
        readReg(REG_DIR, v);
        check("dir", v, 8'h3f);
        check("osc", {6'h00, padOe[7], padOut[7]}, 8'h03);
        clkSelCrystal <= 1'b0;
        clkSelIntRc   <= 1'b0;
        readReg(REG_STATUS, v);
        check("status", v, 8'h02);
        readReg(REG_LATCH, v);
        check("latch", v, 8'h83);
        clkSelIntRc <= 1'b1;
        writeReg(REG_CONTROL, 8'h02);
        readReg(REG_STATUS, v);
        check("status", v, 8'h03);
        readReg(REG_INPUT, v);
        check("input", v, 8'h1a);
        writeReg(REG_CONTROL, 8'h06);
        readReg(REG_STATUS, v);
        check("status", v, 8'h02);
        $display("clock pin test done");
        stop_test();
    end
endmodule : tb_port_pin_override_mux
